// >>> design/sgcr_pkg.sv
// sgcr_pkg: constants shared by the switch global control register bank
// assumes a 100 MHz system clock and byte-wide register access
package sgcr_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] GCTL_ZERO_ADDR = 8'h02;
    localparam logic [ADDR_W-1:0] GCTL_ONE_ADDR = 8'h03;
    localparam logic [DATA_W-1:0] GCTL_ZERO_RST = 8'h44;
    localparam logic [DATA_W-1:0] GCTL_ONE_RST = 8'h34;
    localparam logic [DATA_W-1:0] READ_NONE = 8'h00;
    // global control zero fields
    localparam int GC0_ALT_BACKOFF = 7;
    localparam int GC0_PASS_FC = 3;
    localparam int GC0_LINK_AGE = 0;
    // global control one fields
    localparam int GC1_PASS_ALL = 7;
    localparam int GC1_PAUSE_GEN = 5;
    localparam int GC1_PAUSE_OBEY = 4;
    localparam int GC1_LEN_CHECK = 3;
    localparam int GC1_AGE_EN = 2;
    localparam int GC1_FAST_AGE = 1;
    localparam int GC1_AGGR_BACKOFF = 0;
    // timing
    localparam longint CLK_HZ = 100000000;
    localparam longint AGE_NORMAL_SEC = 200;
    localparam longint AGE_FAST_US = 800;
    localparam int CNT_W = 40;
    localparam logic [CNT_W-1:0] AGE_NORMAL_CYC = CNT_W'(AGE_NORMAL_SEC * CLK_HZ);
    // count runs from zero up to and including the period, so stay one short to tick every 800 us exactly
    localparam logic [CNT_W-1:0] AGE_FAST_CYC = CNT_W'(AGE_FAST_US * CLK_HZ / 1000000 - 1);
    localparam logic [CNT_W-1:0] CNT_ONE = 40'h0000000001;
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
    localparam logic [1:0] STRAP_STEP = 2'h1;
endpackage : sgcr_pkg

// >>> design/sgcr_age_timer.sv
// sgcr_age_timer: address table aging period generator
// assumes the table walks one aging pass per ageTick pulse
`timescale 1ns/100ps
`default_nettype none
module sgcr_age_timer #(
    parameter logic [sgcr_pkg::CNT_W-1:0] NORMAL_CYC = sgcr_pkg::AGE_NORMAL_CYC,
    parameter logic [sgcr_pkg::CNT_W-1:0] FAST_CYC = sgcr_pkg::AGE_FAST_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic ageEn,
    input wire logic fastEn,
    input wire logic linkLossStart,
    output logic ageTick,
    output logic linkPassBusy
);
    logic [sgcr_pkg::CNT_W-1:0] count_r;
    logic [sgcr_pkg::CNT_W-1:0] period;
    logic due;

    assign period = (fastEn || linkPassBusy) ? FAST_CYC : NORMAL_CYC;
    assign due = count_r >= period;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count_r <= '0;
        end else if (ce) begin
            if (!ageEn || linkLossStart || due) begin
                count_r <= '0;
            end else begin
                count_r <= count_r + sgcr_pkg::CNT_ONE;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ageTick <= 1'b0;
        end else if (ce) begin
            ageTick <= ageEn && !linkLossStart && due;
        end
    end

    // one fast pass after a link loss, then back to the normal period
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            linkPassBusy <= 1'b0;
        end else if (ce) begin
            if (!ageEn) begin
                linkPassBusy <= 1'b0;
            end else if (linkLossStart) begin
                linkPassBusy <= 1'b1;
            end else if (due) begin
                linkPassBusy <= 1'b0;
            end
        end
    end
endmodule : sgcr_age_timer
`default_nettype wire

// >>> design/sgcr_regs.sv
// sgcr_regs: two global control registers of a three-port switch
// assumes a single-cycle strobe port master and link-up levels from the ports
//
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module sgcr_regs #(
    parameter int NUM_PORTS = 3,
    parameter logic [sgcr_pkg::CNT_W-1:0] NORMAL_CYC = sgcr_pkg::AGE_NORMAL_CYC,
    parameter logic [sgcr_pkg::CNT_W-1:0] FAST_CYC = sgcr_pkg::AGE_FAST_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [sgcr_pkg::ADDR_W-1:0] regAddr,
    input wire logic [sgcr_pkg::DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [sgcr_pkg::DATA_W-1:0] regRdData,
    input wire logic expiry_strap_pin,
    input wire logic [NUM_PORTS-1:0] linkUp,
    input wire logic snifferMode,
    output logic altBackoffEn,
    output logic passFlowCtrlEn,
    output logic debugPassAll,
    output logic tx_pause_gen_en,
    output logic rx_pause_obey_en,
    output logic lenCheckEn,
    output logic agingEn,
    output logic fastAgeEn,
    output logic aggrBackoffEn,
    output logic ageTick,
    output logic ageFlushAll
);
    logic [sgcr_pkg::DATA_W-1:0] gc0_r;
    logic [sgcr_pkg::DATA_W-1:0] gc1_r;
    logic [2:0] strapSync_r;
    logic [1:0] strapCnt_r;
    logic strapDone_r;
    logic [NUM_PORTS-1:0] linkS1_r;
    logic [NUM_PORTS-1:0] linkS2_r;
    logic [NUM_PORTS-1:0] linkS3_r;
    logic [NUM_PORTS-1:0] linkState_r;
    logic [NUM_PORTS-1:0] linkFilt;
    logic linkLoss;
    logic linkLossStart_r;
    logic linkPassBusy;
    logic ageTickInt;
    logic strapLoad;

    function automatic logic hit(input logic [sgcr_pkg::ADDR_W-1:0] a,
                                 input logic [sgcr_pkg::ADDR_W-1:0] target);
        hit = (a == target);
    endfunction : hit

    // a link level only changes once the second and third stages agree
    assign linkFilt = (linkS2_r == linkS3_r) ? linkS3_r : linkState_r;
    assign linkLoss = |(linkState_r & ~linkFilt);
    assign strapLoad = !strapDone_r && (strapCnt_r == sgcr_pkg::STRAP_SETTLE)
                       && (strapSync_r[1] == strapSync_r[2]);

    // register writes; reserved bits are stored as written
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gc0_r <= sgcr_pkg::GCTL_ZERO_RST;
        end else if (ce && regWr && hit(regAddr, sgcr_pkg::GCTL_ZERO_ADDR)) begin
            gc0_r <= regWrData;
        end
    end

    // strap load takes priority over a write to the aging enable bit only in its single load cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gc1_r <= sgcr_pkg::GCTL_ONE_RST;
        end else if (ce) begin
            if (regWr && hit(regAddr, sgcr_pkg::GCTL_ONE_ADDR)) begin
                gc1_r <= regWrData;
            end
            if (strapLoad) begin
                gc1_r[sgcr_pkg::GC1_AGE_EN] <= ~strapSync_r[2];
            end
        end
    end

    // strap sampling after reset release; the pad level cannot feed an async reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            strapSync_r <= 3'h0;
        end else if (ce) begin
            strapSync_r <= {strapSync_r[1:0], expiry_strap_pin};
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            strapCnt_r <= 2'h0;
            strapDone_r <= 1'b0;
        end else if (ce) begin
            if (strapCnt_r != sgcr_pkg::STRAP_SETTLE) begin
                strapCnt_r <= strapCnt_r + sgcr_pkg::STRAP_STEP;
            end
            if (strapLoad) begin
                strapDone_r <= 1'b1;
            end
        end
    end

    // link-up synchronisers; stage one is read only by stage two
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            linkS1_r <= '0;
            linkS2_r <= '0;
            linkS3_r <= '0;
            linkState_r <= '0;
        end else if (ce) begin
            linkS1_r <= linkUp;
            linkS2_r <= linkS1_r;
            linkS3_r <= linkS2_r;
            linkState_r <= linkFilt;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            linkLossStart_r <= 1'b0;
            ageFlushAll <= 1'b0;
        end else if (ce) begin
            linkLossStart_r <= linkLoss && gc0_r[sgcr_pkg::GC0_LINK_AGE];
            ageFlushAll <= linkLoss;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            regRdData <= sgcr_pkg::READ_NONE;
        end else if (ce) begin
            if (regRd && hit(regAddr, sgcr_pkg::GCTL_ZERO_ADDR)) begin
                regRdData <= gc0_r;
            end else if (regRd && hit(regAddr, sgcr_pkg::GCTL_ONE_ADDR)) begin
                regRdData <= gc1_r;
            end else begin
                regRdData <= sgcr_pkg::READ_NONE;
            end
        end
    end

    // control outputs copy the stored bits, one flop each, with debugPassAll gated by snifferMode
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            altBackoffEn <= 1'b0;
            passFlowCtrlEn <= 1'b0;
            debugPassAll <= 1'b0;
            tx_pause_gen_en <= 1'b1;
            rx_pause_obey_en <= 1'b1;
            lenCheckEn <= 1'b0;
            agingEn <= 1'b1;
            fastAgeEn <= 1'b0;
            aggrBackoffEn <= 1'b0;
            ageTick <= 1'b0;
        end else if (ce) begin
            altBackoffEn <= gc0_r[sgcr_pkg::GC0_ALT_BACKOFF];
            passFlowCtrlEn <= gc0_r[sgcr_pkg::GC0_PASS_FC];
            debugPassAll <= gc1_r[sgcr_pkg::GC1_PASS_ALL] && snifferMode;
            tx_pause_gen_en <= gc1_r[sgcr_pkg::GC1_PAUSE_GEN];
            rx_pause_obey_en <= gc1_r[sgcr_pkg::GC1_PAUSE_OBEY];
            lenCheckEn <= gc1_r[sgcr_pkg::GC1_LEN_CHECK];
            agingEn <= gc1_r[sgcr_pkg::GC1_AGE_EN];
            fastAgeEn <= gc1_r[sgcr_pkg::GC1_FAST_AGE];
            aggrBackoffEn <= gc1_r[sgcr_pkg::GC1_AGGR_BACKOFF];
            ageTick <= ageTickInt;
        end
    end

    sgcr_age_timer #(
        .NORMAL_CYC(NORMAL_CYC),
        .FAST_CYC(FAST_CYC)
    ) u_age (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .ageEn(gc1_r[sgcr_pkg::GC1_AGE_EN]),
        .fastEn(gc1_r[sgcr_pkg::GC1_FAST_AGE]),
        .linkLossStart(linkLossStart_r),
        .ageTick(ageTickInt),
        .linkPassBusy(linkPassBusy)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_gc0_write: assert property (ce && regWr && regAddr == sgcr_pkg::GCTL_ZERO_ADDR
        |=> gc0_r == $past(regWrData))
        else $error("global control zero did not take the write");
    a_read_back: assert property (ce && regRd && regAddr == sgcr_pkg::GCTL_ONE_ADDR
        && !strapLoad |=> regRdData == $past(gc1_r))
        else $error("read data differs from global control one");
    a_alt_backoff: assert property (ce && regWr && regAddr == sgcr_pkg::GCTL_ZERO_ADDR
        ##1 ce |=> altBackoffEn == $past(regWrData[7], 2))
        else $error("alternative back-off does not follow bit 7");
    a_pass_fc: assert property (ce |=> passFlowCtrlEn == $past(gc0_r[3]))
        else $error("flow-control pass does not follow bit 3");
    a_pass_all: assert property (ce && !snifferMode |=> !debugPassAll)
        else $error("pass all frames active outside sniffer mode");
    a_pause_gen: assert property (ce |=> tx_pause_gen_en == $past(gc1_r[5]))
        else $error("pause generation does not follow bit 5");
    a_pause_obey: assert property (ce |=> rx_pause_obey_en == $past(gc1_r[4]))
        else $error("pause obey does not follow bit 4");
    a_len_check: assert property (ce |=> lenCheckEn == $past(gc1_r[3]))
        else $error("length check does not follow bit 3");
    a_age_off: assert property (!gc1_r[sgcr_pkg::GC1_AGE_EN] ##1 ce |=> !ageTick)
        else $error("aging tick while aging disabled");
    a_strap_load: assert property (ce && strapLoad
        |=> gc1_r[2] == !$past(strapSync_r[2]) && strapDone_r)
        else $error("aging enable not loaded from inverted strap");
    a_link_fast: assert property (ce && linkLoss && gc0_r[0] && gc1_r[2]
        ##1 ce |=> linkPassBusy)
        else $error("link loss did not start a fast aging pass");
    a_flush_all: assert property (ce && linkLoss |=> ageFlushAll)
        else $error("link loss did not flush the address table");
    a_aggr_backoff: assert property (ce |=> aggrBackoffEn == $past(gc1_r[0]))
        else $error("aggressive back-off does not follow bit 0");

    c_write_gc1: cover property (ce && regWr && regAddr == sgcr_pkg::GCTL_ONE_ADDR);
    c_link_pass: cover property (linkPassBusy ##1 !linkPassBusy);
    c_strap_done: cover property ($rose(strapDone_r));
    c_flush: cover property (ageFlushAll);
endmodule : sgcr_regs
`default_nettype wire

// >>> test/sgcr_testbench.sv
// testbench: self-checking bench for the switch global control register bank
// assumes sgcr_pkg and sgcr_regs are compiled first; aging periods are shortened
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam logic [sgcr_pkg::CNT_W-1:0] NCYC = 40'h00000000c8;
    localparam logic [sgcr_pkg::CNT_W-1:0] FCYC = 40'h0000000014;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic strap = 1'b0;
    logic [2:0] linkUp = 3'h7;
    logic sniff = 1'b0;
    logic [7:0] regRdData;
    logic [8:0] ctl;
    logic ageTick;
    logic ageFlushAll;
    logic [7:0] m0 = 8'h44;
    logic [7:0] m1 = 8'h34;
    logic [31:0] seed = 32'h00000015;
    int nErrors = 0;
    int testsRun = 0;
    int n;
    int f;

    sgcr_regs #(.NUM_PORTS(3), .NORMAL_CYC(NCYC), .FAST_CYC(FCYC)) i_dut (
        .clk(clk), .nrst(nrst), .ce(ce), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .expiry_strap_pin(strap),
        .linkUp(linkUp), .snifferMode(sniff), .altBackoffEn(ctl[8]),
        .passFlowCtrlEn(ctl[7]), .debugPassAll(ctl[6]), .tx_pause_gen_en(ctl[5]),
        .rx_pause_obey_en(ctl[4]), .lenCheckEn(ctl[3]), .agingEn(ctl[2]),
        .fastAgeEn(ctl[1]), .aggrBackoffEn(ctl[0]), .ageTick(ageTick),
        .ageFlushAll(ageFlushAll));

    always #5 clk = ~clk;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    function automatic logic [8:0] expCtl();
        return {m0[7], m0[3], m1[7] & sniff, m1[5], m1[4], m1[3], m1[2], m1[1], m1[0]};
    endfunction : expCtl

    function automatic logic [7:0] mdl(input logic [7:0] a);
        return (a == 8'h02) ? m0 : ((a == 8'h03) ? m1 : 8'h00);
    endfunction : mdl

    task automatic tallyAndFinish();
        if (nErrors == 0 && testsRun > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tallyAndFinish

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        testsRun++;
        if (seen !== exp) begin
            nErrors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // every task that waits on the clock leaves just after an edge, so strobes change once per time step
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        regWr <= w;
        regRd <= r;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        #1;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
        if (ce && a == 8'h02) m0 = d;
        if (ce && a == 8'h03) m1 = d;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        logic [7:0] e;
        e = mdl(a);
        bus(1'b0, 1'b1, a, 8'h00);
        chk(16'(regRdData), 16'(e));
    endtask : rd

    task automatic idle();
        logic [31:0] r;
        r = xs();
        bus(1'b0, 1'b0, r[7:0], r[15:8]);
    endtask : idle

    task automatic waitTick();
        n = 0;
        f = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
            f += int'(ageFlushAll === 1'b1);
        end while (ageTick !== 1'b1 && n < 1000);
    endtask : waitTick

    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        // strap load needs the synchroniser full before the first look
        repeat (8) @(posedge clk);
        #1;
        chk(16'(ctl), 16'(expCtl()));
        rd(8'h02);
        rd(8'h03);
        idle();
        chk(16'(regRdData), 16'h0000);
        for (int i = 0; i < 24; i++) begin
            logic [31:0] r;
            logic [7:0] a;
            logic [7:0] d;
            r = xs();
            sniff <= r[8];
            a = (r[1:0] == 2'h0) ? 8'h02 : ((r[1:0] == 2'h1) ? 8'h03 : (r[2] ? 8'h7f : 8'h04));
            // reserved bits stay at their reset levels, as software must keep them
            d = (a == 8'h02) ? ((r[23:16] & 8'h89) | 8'h44) : (r[23:16] & 8'hbf);
            wr(a, d);
            rd(a);
            idle();
            chk(16'(regRdData), 16'h0000);
            chk(16'(ctl), 16'(expCtl()));
        end
        ce <= 1'b0;
        wr(8'h02, 8'hcd);
        ce <= 1'b1;
        rd(8'h02);
        wr(8'h03, 8'h36);
        idle();
        waitTick();
        waitTick();
        chk(16'(n), 16'(FCYC + 1));
        wr(8'h03, 8'h34);
        idle();
        waitTick();
        waitTick();
        chk(16'(n), 16'(NCYC + 1));
        wr(8'h03, 8'h30);
        idle();
        waitTick();
        chk(16'(n), 16'd1000);
        wr(8'h03, 8'h34);
        wr(8'h02, 8'h45);
        idle();
        waitTick();
        linkUp <= 3'h5;
        waitTick();
        chk(16'(f), 16'h0001);
        chk(16'(n >= 20 && n <= 30), 16'h0001);
        waitTick();
        chk(16'(n), 16'(NCYC + 1));
        linkUp <= 3'h7;
        // second reset with the strap driven high turns aging off
        strap <= 1'b1;
        nrst <= 1'b0;
        m0 = 8'h44;
        m1 = 8'h30;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (8) @(posedge clk);
        #1;
        chk(16'(ctl), 16'(expCtl()));
        rd(8'h03);
        rd(8'h02);
        idle();
        tallyAndFinish();
    end

    // whole run is a few thousand cycles; this bound leaves ample margin
    initial begin
        #100000;
        nErrors++;
        tallyAndFinish();
    end
endmodule : testbench
`default_nettype wire
